// ==== ssbc_core.sv ====
// Operation
// - load edge with all selects active and store high starts a read burst
// - step_or_load high ignores selects, keeps burst type, advances counter
// - load with store low, selects active, any lane low starts a write burst
// - store low with no lane active writes nothing; data pins stay off
// - load with any select inactive deselects; data pins off
// - continue after deselect stays deselected; write abort at load deselects
// - read with output enable high is a dummy read, pins off
// - drivers turned off during write cycles whatever output enable does
// - clock_hold_n high freezes burst and write state but not sleep counting; read output keeps driving while output enable is low
// - two-bit burst counter wraps to the loaded value after four addresses
// - linear order adds count to loaded low bits modulo four
// - interleaved order xors loaded low bits with the count
// - flow_through_select_n low gives flow-through, high gives pipeline
// - sleep_request low means active operation, high means standby
// - sleep entered two cycles after request; state kept, outputs off
// - two cycles of wake-up after request returns low
// - outputs high-impedance from power-up (reset)
// - pipeline read data appears after the edge following the command
// - each lane write strobe gates one nine-bit data lane
`timescale 1ns/1ps
module ssbc_core
  import ssbc_pkg::*;
#(
  parameter int ADDR_W = ssbc_pkg::ADDR_W_DEF,
  parameter int LANES  = ssbc_pkg::LANES_DEF
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // command pins
  input  wire logic                       clock_hold_n,
  input  wire logic                       step_or_load,
  input  wire logic                       store_strobe_n,
  input  wire logic                       chip_select1_n,
  input  wire logic                       chip_select2,
  input  wire logic                       chip_select3_n,
  input  wire logic [LANES-1:0]           lane_write_n,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic                       output_enable_n,
  // mode pins
  input  wire logic                       sequential_order_n,
  input  wire logic                       flow_through_select_n,
  input  wire logic                       sleep_request,
  // data pins
  input  wire logic [LANES*ssbc_pkg::LANE_W-1:0] dq_in,
  output logic [LANES*ssbc_pkg::LANE_W-1:0]      dq_out,
  output logic [LANES*ssbc_pkg::LANE_W-1:0]      dq_oe,
  // status
  output logic                            asleep
);
  import ssbc_pkg::*;

  localparam int DW    = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  initial begin
    if (ADDR_W < BURST_W || ADDR_W > 16 || LANES < 1 || LANES > 8) begin
      $error("ssbc_core: unsupported parameters");
    end
  end

  typedef struct packed {
    ssbc_op_t              op;
    logic [ADDR_W-1:0]     base;
    logic [BURST_W-1:0]    cnt;
    logic                  interleave;
    // write pipeline: slot 0 is the newest accepted write
    logic [WR_DLY_W-1:0]   wv;
    logic [WR_DLY_W-1:0][ADDR_W-1:0] wa;
    logic [WR_DLY_W-1:0][LANES-1:0]  wl;
    logic                  rd_pend;
    logic                  rd_show;
    logic [DW-1:0]         rd_data;
    logic [DW-1:0]         q;
    logic                  drive;
    logic [SLP_CNT_W-1:0]  slp_cnt;
    logic                  sleep;
    logic [SLP_CNT_W-1:0]  wake_cnt;
  } ssbc_state_t;

  ssbc_state_t st_ff;
  ssbc_state_t nxt_st;
  logic [DW-1:0] mem [DEPTH];

  logic              sel_all;
  logic              any_lane;
  logic [ADDR_W-1:0] cur_addr;
  logic [BURST_W-1:0] low_bits;
  logic              wr_now;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0]  wr_lanes;
  logic              go;
  logic              pipe_mode;
  logic              rd_access;
  logic [ADDR_W-1:0] rd_addr;

  assign sel_all  = !chip_select1_n && chip_select2 && !chip_select3_n;
  assign any_lane = ~&lane_write_n;
  assign pipe_mode = flow_through_select_n;
  // edges gated by hold and by sleep
  assign go = !clock_hold_n && !st_ff.sleep;

  always_comb begin
    low_bits = st_ff.interleave ? (st_ff.base[BURST_W-1:0] ^ st_ff.cnt)
                                : BURST_W'(st_ff.base[BURST_W-1:0] + st_ff.cnt);
    cur_addr = {st_ff.base[ADDR_W-1:BURST_W], low_bits};
  end

  always_comb begin
    // write data taken one or two edges after the command edge
    wr_now   = pipe_mode ? st_ff.wv[1] : st_ff.wv[0];
    wr_addr  = pipe_mode ? st_ff.wa[1] : st_ff.wa[0];
    wr_lanes = pipe_mode ? st_ff.wl[1] : st_ff.wl[0];
  end

  always_comb begin
    nxt_st    = st_ff;
    rd_access = 1'b0;
    rd_addr   = cur_addr;
    // sleep_request low is active; entry and wake-up counting
    if (sleep_request) begin
      nxt_st.wake_cnt = '0;
      if (!st_ff.sleep) begin
        if (st_ff.slp_cnt == SLP_CNT_W'(SLEEP_IN_CYC - 1)) begin
          nxt_st.sleep = 1'b1;
        end else begin
          nxt_st.slp_cnt = st_ff.slp_cnt + 1'b1;
        end
      end
    end else begin
      nxt_st.slp_cnt = '0;
      if (st_ff.sleep) begin
        if (st_ff.wake_cnt == SLP_CNT_W'(WAKE_CYC - 1)) begin
          nxt_st.sleep    = 1'b0;
          nxt_st.wake_cnt = '0;
        end else begin
          nxt_st.wake_cnt = st_ff.wake_cnt + 1'b1;
        end
      end
    end
    if (go) begin
      nxt_st.wv = {st_ff.wv[0], 1'b0};
      nxt_st.wa = {st_ff.wa[0], st_ff.wa[0]};
      nxt_st.wl = {st_ff.wl[0], st_ff.wl[0]};
      if (step_or_load) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
        rd_addr    = {st_ff.base[ADDR_W-1:BURST_W],
                      st_ff.interleave ? (st_ff.base[BURST_W-1:0] ^ BURST_W'(st_ff.cnt + 1'b1))
                                       : BURST_W'(st_ff.base[BURST_W-1:0] + st_ff.cnt + 1'b1)};
        unique case (st_ff.op)
          SSBC_OP_READ:  rd_access = 1'b1;
          // continuation with no lane active writes nothing
          SSBC_OP_WRITE: begin
            nxt_st.wv[0] = any_lane;
            nxt_st.wa[0] = rd_addr;
            nxt_st.wl[0] = ~lane_write_n;
          end
          SSBC_OP_DESEL: ;
        endcase
      end else begin
        nxt_st.base       = addr;
        nxt_st.cnt        = BURST_ZERO;
        nxt_st.interleave = sequential_order_n;
        rd_addr           = addr;
        if (!sel_all) begin
          nxt_st.op = SSBC_OP_DESEL;
        end else if (store_strobe_n) begin
          nxt_st.op = SSBC_OP_READ;
          rd_access = 1'b1;
        end else if (any_lane) begin
          nxt_st.op    = SSBC_OP_WRITE;
          nxt_st.wv[0] = 1'b1;
          nxt_st.wa[0] = addr;
          nxt_st.wl[0] = ~lane_write_n;
        end else begin
          nxt_st.op = SSBC_OP_DESEL;
        end
      end
      // read data staged one edge in pipeline mode
      nxt_st.rd_pend = rd_access;
      nxt_st.rd_show = pipe_mode ? st_ff.rd_pend : rd_access;
      nxt_st.rd_data = mem[rd_addr];
      nxt_st.q       = pipe_mode ? st_ff.rd_data : mem[rd_addr];
      // drive only on shown reads with output enable low
      nxt_st.drive   = (pipe_mode ? st_ff.rd_pend : rd_access) && !output_enable_n;
    end else if (!clock_hold_n || st_ff.sleep) begin
      nxt_st.drive = 1'b0;
    end
    // hold keeps drive unless sleep is entered or output enable is high, writes keep it off
    if (sleep_request && !st_ff.sleep && st_ff.slp_cnt == SLP_CNT_W'(SLEEP_IN_CYC - 1)) begin
      nxt_st.drive = 1'b0;
    end
    if (st_ff.drive && output_enable_n) begin
      nxt_st.drive = 1'b0;
    end
  end

  // lane gated write into the array
  always_ff @(posedge clk) begin
    if (!rst && go && wr_now) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr_lanes[l]) begin
          mem[wr_addr][l*LANE_W +: LANE_W] <= dq_in[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.op   <= SSBC_OP_DESEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DW; gi++) begin : g_dq
      always_ff @(posedge clk) begin
        if (rst) begin
          dq_out[gi] <= 1'b0;
          dq_oe[gi]  <= 1'b0;
        end else begin
          dq_out[gi] <= nxt_st.q[gi];
          dq_oe[gi]  <= nxt_st.drive;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      asleep <= 1'b0;
    end else begin
      asleep <= nxt_st.sleep;
    end
  end

  chk_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_request) && !st_ff.sleep ##1 sleep_request |=> st_ff.sleep)
    else $error("sleep not entered two cycles after request");
  chk_wake_time: assert property (@(posedge clk) disable iff (rst)
    st_ff.sleep && !sleep_request ##1 !sleep_request |=> !st_ff.sleep)
    else $error("wake-up did not take two cycles");
  chk_sleep_quiet: assert property (@(posedge clk) disable iff (rst)
    st_ff.sleep |=> ##1 (dq_oe == '0))
    else $error("pins driven during sleep");
  // flow-through: no drive at the write data edge
  chk_write_off: assert property (@(posedge clk) disable iff (rst)
    go && !pipe_mode && !step_or_load && sel_all && !store_strobe_n |=> (dq_oe == '0))
    else $error("pins driven on write");
  // pipeline: earlier read may finish, write data edge stays undriven
  chk_write_off_pipe: assert property (@(posedge clk) disable iff (rst)
    go && pipe_mode && !step_or_load && sel_all && !store_strobe_n ##1 go |=> (dq_oe == '0))
    else $error("pins driven at pipelined write data edge");
  chk_desel_off: assert property (@(posedge clk) disable iff (rst)
    go && !step_or_load && !sel_all
    |=> st_ff.op == SSBC_OP_DESEL && (pipe_mode || dq_oe == '0) ##1 (dq_oe == '0) || !pipe_mode)
    else $error("deselect did not stop drive");
  // read load in pipeline drives one edge later
  chk_read_pipe: assert property (@(posedge clk) disable iff (rst)
    go && pipe_mode && !step_or_load && sel_all && store_strobe_n
    ##1 (go && pipe_mode && !output_enable_n) |=> dq_oe[0])
    else $error("pipelined read data not driven");
  chk_burst_wrap: assert property (@(posedge clk) disable iff (rst)
    go && step_or_load && st_ff.cnt == 2'h3 |=> st_ff.cnt == BURST_ZERO)
    else $error("burst counter did not wrap");
  chk_hold_freeze: assert property (@(posedge clk) disable iff (rst)
    clock_hold_n |=> $stable(st_ff.cnt) && $stable(st_ff.base) && $stable(st_ff.op))
    else $error("state changed on held edge");
  // output enable high keeps pins off
  chk_oe_high: assert property (@(posedge clk) disable iff (rst)
    output_enable_n |=> (dq_oe == '0))
    else $error("pins driven with output enable high");

  cov_read_burst: cover property (@(posedge clk) st_ff.op == SSBC_OP_READ && st_ff.cnt == 2'h3);
  cov_write_burst: cover property (@(posedge clk) st_ff.op == SSBC_OP_WRITE && st_ff.cnt == 2'h3);
  cov_sleep: cover property (@(posedge clk) $fell(st_ff.sleep));
  cov_interleave: cover property (@(posedge clk) st_ff.interleave && st_ff.cnt == BURST_ONE);
endmodule : ssbc_core

// ==== ssbc_pkg.sv ====
package ssbc_pkg;
  localparam int ADDR_W_DEF    = 8;
  localparam int LANES_DEF     = 4;
  localparam int LANE_W        = 9;
  localparam int BURST_LEN     = 4;
  localparam int BURST_W       = 2;
  localparam int SLEEP_IN_CYC  = 2;
  localparam int WAKE_CYC      = 2;
  localparam int SLP_CNT_W     = 2;
  // write data edge, counted from the command edge as the first
  localparam int WR_EDGE_PIPE  = 3;
  localparam int WR_EDGE_FLOW  = 2;
  localparam int WR_DLY_W      = 2;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [1:0] BURST_ONE  = 2'h1;

  typedef enum logic [2:0] {
    SSBC_OP_DESEL = 3'b001,
    SSBC_OP_READ  = 3'b010,
    SSBC_OP_WRITE = 3'b100
  } ssbc_op_t;
endpackage : ssbc_pkg

// ==== ssbc_host_model.sv ====
`timescale 1ns/1ps
module ssbc_host_model
  import ssbc_pkg::*;
#(
  parameter int DW = 36
) (
  // clock and mode
  input  wire logic          clk,
  input  wire logic          clock_hold_n,
  input  wire logic          flow_through_select_n,
  // write data handed over at the command edge
  input  wire logic          wr_go,
  input  wire logic [DW-1:0] wr_data,
  // data pins
  input  wire logic [DW-1:0] dq_out,
  input  wire logic [DW-1:0] dq_oe,
  output logic      [DW-1:0] dq_in
);
  logic [DW-1:0] d1_ff   = '0;
  logic [DW-1:0] out_ff  = '0;
  logic [DW-1:0] junk_ff = '0;
  logic          v1_ff   = 1'b0;
  logic          vo_ff   = 1'b0;
  always_ff @(posedge clk) begin
    junk_ff <= ~junk_ff;
    if (!clock_hold_n) begin
      d1_ff  <= wr_data;
      v1_ff  <= wr_go;
      out_ff <= flow_through_select_n ? d1_ff : wr_data;
      vo_ff  <= flow_through_select_n ? v1_ff : wr_go;
    end
  end
  // a released bus shows a pattern that changes every cycle
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & (vo_ff ? out_ff : junk_ff));
endmodule : ssbc_host_model

// ==== sync_sram_burst_control_tb.sv ====
`timescale 1ns/1ps
module sync_sram_burst_control_tb;
  import ssbc_pkg::*;
  localparam int DW = LANES_DEF * LANE_W;
  typedef struct { logic [DW-1:0] d; int e; } ssbc_note_t;
  logic          clk, rst, clock_hold_n, step_or_load, store_strobe_n, asleep;
  logic          chip_select1_n, chip_select2, chip_select3_n, output_enable_n;
  logic          sequential_order_n, flow_through_select_n, sleep_request;
  logic          wr_go, tk, zz, ord;
  logic [3:0]    lane_write_n;
  logic [7:0]    addr, base, a;
  logic [1:0]    cnt;
  logic [DW-1:0] dq_in, dq_out, dq_oe, wr_data, po, pd;
  logic [DW-1:0] mem [256];
  logic [31:0]   seed = 32'h0000_1294;
  int            failures, n_checks, ecnt, mcnt, typ;
  ssbc_note_t    notes[$];
  ssbc_note_t    nt;

  ssbc_core dut_u (.clk, .rst, .clock_hold_n, .step_or_load, .store_strobe_n, .chip_select1_n,
    .chip_select2, .chip_select3_n, .lane_write_n, .addr, .output_enable_n, .sequential_order_n,
    .flow_through_select_n, .sleep_request, .dq_in, .dq_out, .dq_oe, .asleep);
  ssbc_host_model #(.DW(DW)) host_u (.clk, .clock_hold_n, .flow_through_select_n, .wr_go,
    .wr_data, .dq_out, .dq_oe, .dq_in);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp_data(input logic [DW-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_flag(input logic got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic beat(input logic h, s, w, input logic [2:0] cs, input logic [3:0] ln,
                      input logic [7:0] ad, input logic oe);
    logic [7:0]    ea;
    logic [DW-1:0] wd;
    @(negedge clk);
    wd = DW'({rnd(), rnd()});
    {clock_hold_n, step_or_load, store_strobe_n, chip_select1_n, chip_select2, chip_select3_n} = {h, s, w, cs};
    {lane_write_n, addr, output_enable_n, wr_data, wr_go} = {ln, ad, oe, wd, 1'b0};
    tk = !h && !zz;
    if (tk) begin
      ecnt++;
      if (!s) begin
        base = ad;
        cnt = 2'h0;
        ord = sequential_order_n;
        typ = (cs != 3'b010) ? 0 : w ? 1 : (ln != 4'hf) ? 2 : 0;
      end else begin
        cnt++;
      end
      ea = {base[7:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
      if (typ == 1 && !oe) notes.push_back('{mem[ea], ecnt + int'(flow_through_select_n)});
      if (typ == 2) begin
        wr_go = 1'b1;
        for (int i = 0; i < 4; i++) if (!ln[i]) mem[ea][i*9 +: 9] = wd[i*9 +: 9];
      end
    end
  endtask : beat

  task automatic idle(input int n, input logic oe);
    repeat (n) beat(1'b0, 1'b0, 1'b1, 3'b111, 4'hf, 8'h00, oe);
  endtask : idle

  task automatic burst(input logic w, input logic [3:0] ln, input logic rl, oe);
    beat(1'b0, 1'b0, w, 3'b010, ln, a, oe);
    beat(1'b1, 1'(rnd()), 1'(rnd()), 3'(rnd()), 4'(rnd()), 8'(rnd()), oe);
    repeat (4) beat(1'b0, 1'b1, 1'(rnd()), 3'(rnd()), rl ? 4'(rnd()) : ln, 8'(rnd()), oe);
  endtask : burst

  // results are compared as they appear on the pins
  always @(posedge clk) begin
    if (!rst) begin
      po = dq_oe;
      pd = dq_out;
      if (tk) mcnt++;
      #1;
      if (!tk) begin
        cmp_data(dq_oe, po);
        cmp_data(dq_out & po, pd & po);
      end else if (dq_oe !== '0 || (notes.size() > 0 && notes[0].e == mcnt)) begin
        if (notes.size() == 0) cmp_data(dq_oe, '0);
        else begin
          nt = notes.pop_front();
          cmp_data(DW'(nt.e), DW'(mcnt));
          cmp_data(dq_oe, '1);
          cmp_data(dq_out, nt.d);
        end
      end
    end
  end

  initial begin
    {rst, clock_hold_n, step_or_load, store_strobe_n, chip_select1_n, chip_select2, chip_select3_n} = 7'h4d;
    {lane_write_n, addr, output_enable_n, sequential_order_n, flow_through_select_n} = 15'h7801;
    {sleep_request, wr_go, wr_data, tk, zz} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      flow_through_select_n = m[0];
      for (int o = 0; o < 2; o++) begin
        sequential_order_n = o[0];
        a = 8'(rnd());
        burst(1'b0, 4'h0, 1'b0, 1'b0);
        burst(1'b0, o ? 4'hf : 4'(rnd()) & 4'he, 1'b1, 1'b0);
        idle(2, 1'b0);
        burst(1'b1, 4'hf, 1'b0, 1'b0);
      end
      idle(2, 1'b0);
      burst(1'b1, 4'hf, 1'b0, 1'b1);
      idle(1, 1'b1);
      for (int k = 0; k < 3; k++) begin
        beat(1'b0, 1'b0, 1'b1, 3'b010 ^ 3'(1 << k), 4'h0, a, 1'b0);
        beat(1'b0, 1'b1, 1'b1, 3'b010, 4'h0, a, 1'b0);
      end
      sleep_request = 1'b1;
      idle(2, 1'b0);
      zz = 1'b1;
      beat(1'b0, 1'b0, 1'b0, 3'b010, 4'h0, a, 1'b0);
      cmp_flag(asleep, 1'b1);
      beat(1'b0, 1'b0, 1'b1, 3'b010, 4'h0, a, 1'b0);
      sleep_request = 1'b0;
      idle(2, 1'b0);
      zz = 1'b0;
      idle(1, 1'b0);
      cmp_flag(asleep, 1'b0);
      burst(1'b1, 4'hf, 1'b0, 1'b0);
      idle(3, 1'b0);
    end
    cmp_data(DW'(notes.size()), '0);
    summarize();
  end

  initial begin
    #1_000_000;
    failures++;
    summarize();
  end
endmodule : sync_sram_burst_control_tb
